// ### src/rtvcal_top.sv
// Function
// (RQ1) Calibrate a channel's VCO after reset, on clock-recovery reset and after four failed locks.
// (RQ2) Calibration steps through every coarse setting and measures the reference-timed count.
// (RQ3) The setting with the smallest count error is kept and used until the next calibration.
// (RQ4) The target count is taken from the host-programmed expected count of the channel.
// (RQ5) Output swing and de-emphasis are only ever what the host writes.
// (RQ6) Every setting is stored separately for each of the four channels.
// (RQ7) The linear equalizer boost holds four stages of two bits each.
// (RQ8) Adaptation select resets to linear equalizer only.
// (RQ9) Five feedback taps are held, each a weight with a polarity bit.
// (RQ10) The feedback equalizer powerdown bit resets set and must be cleared by the host.
// (RQ11) The adaptation select field drives the adaptation mode outputs.
// (RQ12) A new lock is checked against the reference count and rejected when wrong.
// (RQ13) Frequency checking depends on the host writing the rate and expected counts; the check here reads only the expected counts and tolerance, not the rate.
// (RQ14) Adaptation restarts on clock-recovery reset and on each accepted lock.
// (RQ15) The top bit of each upper count register flags a manually loaded count.
// (RQ16) A lock is accepted only within tolerance of an expected count, else it is a failure.
`timescale 1ns/100ps
`include "rtvcal_consts.svh"
module rtvcal_top #(
  parameter int COARSE_W = 5,
  parameter int CNT_W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic SMB_SCL_I,
  input wire logic SMB_SDA_I,
  output logic SMB_SDA_O,
  output logic SMB_SDA_OE_N_O,
  input wire logic [3:0] LOCK_I,
  input wire logic [3:0] CDR_RESET_I,
  input wire logic [3:0] ACQ_FAIL_TGL_I,
  input wire logic MEAS_DONE_I,
  input wire logic [CNT_W-1:0] MEAS_COUNT_I,
  output logic MEAS_REQ_O,
  output logic [1:0] MEAS_CH_O,
  output logic [COARSE_W-1:0] COARSE_TRY_O,
  output logic [4*COARSE_W-1:0] COARSE_O,
  output logic [3:0] LOCK_OK_O,
  output logic [3:0] CDR_RESTART_O,
  output logic [3:0] ADAPT_START_O,
  output logic [3:0] FEEDBACK_EQ_POWERDOWN_O,
  output logic [7:0] ADAPT_MODE_O,
  output logic [15:0] RATE_SEL_O,
  output logic [31:0] LINEAR_EQUALIZER_BOOST_O,
  output logic [31:0] OUTPUT_SWING_O,
  output logic [31:0] DEEMPH_O,
  output logic [159:0] FBEQ_TAP_O
);
  import rtvcal_pkg::*;

  if (COARSE_W < 1 || COARSE_W > 8 || CNT_W < 15) begin : g_chk
    $error("rtvcal_top: COARSE_W must be 1..8 and CNT_W at least 15");
  end

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [12:0] s3;
    logic [12:0] f;
    logic [3:0][15:0][7:0] regs;
    logic [1:0] chsel;
    logic bcast;
    rtvcal_cst_t cst;
    logic chk;
    logic [1:0] ch;
    logic [COARSE_W-1:0] code;
    logic [COARSE_W-1:0] best;
    logic [CNT_W-1:0] best_err;
    logic [3:0] cal_pend;
    logic [3:0] chk_pend;
    logic [3:0] lock_ok;
    logic [3:0] restart;
    logic [3:0] adapt;
    logic [3:0][2:0] fails;
    logic [3:0][COARSE_W-1:0] coarse;
    logic req;
  } rtvcal_st_t;

  rtvcal_st_t q;
  rtvcal_st_t n;
  logic wr;
  rtvcal_byte_t waddr;
  rtvcal_byte_t wdata;
  rtvcal_byte_t raddr;
  rtvcal_byte_t rdata;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [4:0] reg_index(input rtvcal_byte_t ofs);
    case (ofs)
      `RTV_OFS_FBEQ_PWR: reg_index = {1'b1, `RTV_IX_FBEQ};
      `RTV_OFS_RATE: reg_index = {1'b1, `RTV_IX_RATE};
      `RTV_OFS_ADAPT: reg_index = {1'b1, `RTV_IX_ADAPT};
      `RTV_OFS_BOOST: reg_index = {1'b1, `RTV_IX_BOOST};
      `RTV_OFS_SWING: reg_index = {1'b1, `RTV_IX_SWING};
      `RTV_OFS_DEEMPH: reg_index = {1'b1, `RTV_IX_DEEMPH};
      default: begin
        if (ofs >= `RTV_OFS_G0_LO && ofs <= `RTV_OFS_TOL) begin
          reg_index = {1'b1, `RTV_IX_G0_LO + 4'(ofs - `RTV_OFS_G0_LO)};
        end else if (ofs >= `RTV_OFS_TAP0 && ofs <= `RTV_OFS_TAP4) begin
          reg_index = {1'b1, `RTV_IX_TAP0 + 4'(ofs - `RTV_OFS_TAP0)};
        end else begin
          reg_index = 5'h00;
        end
      end
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] abs_diff(input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // The flag bit is not part of the count; without it the count field is used as written.
  function automatic logic [CNT_W-1:0] expect_cnt(input logic [7:0] lo, input logic [7:0] hi);
    expect_cnt = CNT_W'({hi[`RTV_BIT_MANUAL-1:0], lo}); // RQ4 RQ15
  endfunction

  function automatic logic [1:0] lowest(input logic [3:0] v);
    lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  rtvcal_smbus u_smbus (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .scl_i(SMB_SCL_I),
    .sda_i(SMB_SDA_I),
    .sda_o(SMB_SDA_O),
    .sda_oe_n_o(SMB_SDA_OE_N_O),
    .wr_o(wr),
    .waddr_o(waddr),
    .wdata_o(wdata),
    .raddr_o(raddr),
    .rdata_i(rdata)
  );

  always_comb begin
    logic [4:0] ix;
    ix = reg_index(raddr);
    case (raddr)
      `RTV_OFS_CHSEL: rdata = {5'h00, q.bcast, q.chsel};
      `RTV_OFS_COARSE: rdata = 8'(q.coarse[q.chsel]);
      `RTV_OFS_STAT: begin
        rdata = {3'h0, q.fails[q.chsel], q.lock_ok[q.chsel], q.cal_pend[q.chsel]};
      end
      default: rdata = ix[4] ? q.regs[q.chsel][ix[3:0]] : 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Calibration and lock checking
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] wix;
    logic [3:0] tgt;
    logic [3:0] host_cal;
    logic [3:0] host_adapt;
    logic [3:0] fhit;
    logic [3:0] lock_rise;
    logic [3:0] lock_fall;
    logic [3:0] cdr_rise;
    logic [3:0] fail_ev;
    logic [CNT_W-1:0] e0;
    logic [CNT_W-1:0] e1;
    logic [2:0] cnt;
    logic [7:0] r_tol;
    wix = reg_index(waddr);
    tgt = 4'h0;
    host_cal = 4'h0;
    host_adapt = 4'h0;
    fhit = 4'h0;
    cnt = 3'h0;
    n = q;
    n.restart = 4'h0;
    n.adapt = 4'h0;
    n.s1 = {MEAS_DONE_I, ACQ_FAIL_TGL_I, CDR_RESET_I, LOCK_I};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
    lock_rise = n.f[3:0] & ~q.f[3:0];
    lock_fall = ~n.f[3:0] & q.f[3:0];
    cdr_rise = n.f[7:4] & ~q.f[7:4];
    fail_ev = n.f[11:8] ^ q.f[11:8];
    e0 = abs_diff(MEAS_COUNT_I, expect_cnt(q.regs[q.ch][`RTV_IX_G0_LO],
                                           q.regs[q.ch][`RTV_IX_G0_HI]));
    e1 = abs_diff(MEAS_COUNT_I, expect_cnt(q.regs[q.ch][`RTV_IX_G1_LO],
                                           q.regs[q.ch][`RTV_IX_G1_HI]));
    r_tol = q.regs[q.ch][`RTV_IX_TOL];
    if (wr) begin
      tgt = q.bcast ? 4'hF : 4'h1 << q.chsel;
      if (waddr == `RTV_OFS_CHSEL) begin
        n.chsel = wdata[1:0];
        n.bcast = wdata[`RTV_CHSEL_BCAST_BIT];
      end else if (waddr == `RTV_OFS_CMD) begin
        host_cal = tgt & {4{wdata[`RTV_CMD_CAL_BIT]}};
        host_adapt = tgt & {4{wdata[`RTV_CMD_ADAPT_BIT]}};
      end else if (wix[4]) begin
        for (int c = 0; c < 4; c++) begin
          if (tgt[c]) begin
            n.regs[c][wix[3:0]] = wdata; // RQ6 RQ5 RQ9 RQ13
          end
        end
      end
    end
    case (q.cst)
      CAL_IDLE: begin
        if (|q.cal_pend) begin
          n.ch = lowest(q.cal_pend);
          n.chk = 1'b0;
          n.code = '0;
          n.best = '0;
          n.best_err = '1;
          n.req = 1'b1;
          n.cst = CAL_REQ;
        end else if (|q.chk_pend) begin
          n.ch = lowest(q.chk_pend);
          n.chk = 1'b1;
          n.code = q.coarse[lowest(q.chk_pend)];
          n.req = 1'b1;
          n.cst = CAL_REQ;
        end
      end
      CAL_REQ: begin
        // The count is stable once the synchronised done level is high, until the raw done level falls.
        if (q.f[12]) begin
          n.req = 1'b0;
          n.cst = CAL_REL;
          if (!q.chk) begin
            if (e0 < q.best_err) begin
              n.best = q.code; // RQ3
              n.best_err = e0;
            end
            if (q.code == '1) begin
              n.coarse[q.ch] = n.best; // RQ3
              n.cal_pend[q.ch] = 1'b0;
            end
          end else begin
            n.chk_pend[q.ch] = 1'b0;
            if (e0 <= CNT_W'(r_tol[3:0]) || e1 <= CNT_W'(r_tol[7:4])) begin // RQ16
              n.lock_ok[q.ch] = 1'b1;
              n.fails[q.ch] = 3'h0;
              n.adapt[q.ch] = 1'b1; // RQ14
            end else begin
              n.restart[q.ch] = 1'b1; // RQ12
              fhit[q.ch] = 1'b1; // RQ16
            end
          end
        end
      end
      CAL_REL: begin
        if (!q.f[12]) begin
          if (!q.chk && q.code != '1) begin
            n.code = q.code + 1'b1; // RQ2
            n.req = 1'b1;
            n.cst = CAL_REQ;
          end else begin
            n.cst = CAL_IDLE;
          end
        end
      end
      default: begin
        n.cst = CAL_IDLE;
        n.req = 1'b0;
      end
    endcase
    // Events are applied after the engine so that a new event beats a same-cycle clear.
    n.cal_pend = n.cal_pend | cdr_rise | host_cal; // RQ1
    n.adapt = n.adapt | cdr_rise | host_adapt; // RQ14
    n.lock_ok = n.lock_ok & ~(cdr_rise | lock_fall);
    n.chk_pend = (n.chk_pend | lock_rise) & ~lock_fall; // RQ12
    for (int c = 0; c < 4; c++) begin
      cnt = n.fails[c] + {2'h0, fhit[c]} + {2'h0, fail_ev[c]};
      if (cdr_rise[c]) begin
        n.fails[c] = 3'h0;
      end else if (cnt >= `RTV_LOCK_TRIES) begin
        n.fails[c] = 3'h0;
        n.cal_pend[c] = 1'b1; // RQ1
      end else begin
        n.fails[c] = cnt;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= '0;
      q.cal_pend <= 4'hF; // RQ1
      for (int c = 0; c < 4; c++) begin
        q.regs[c][`RTV_IX_FBEQ] <= `RTV_RST_FBEQ_PWR; // RQ10
        q.regs[c][`RTV_IX_ADAPT] <= `RTV_RST_ADAPT; // RQ8
      end
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign MEAS_REQ_O = q.req;
  assign MEAS_CH_O = q.ch;
  assign COARSE_TRY_O = q.code;
  assign LOCK_OK_O = q.lock_ok;
  assign CDR_RESTART_O = q.restart;
  assign ADAPT_START_O = q.adapt;

  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign COARSE_O[c*COARSE_W +: COARSE_W] = q.coarse[c];
    assign FEEDBACK_EQ_POWERDOWN_O[c] = q.regs[c][`RTV_IX_FBEQ][`RTV_BIT_FBEQ_PD]; // RQ10
    assign ADAPT_MODE_O[c*2 +: 2] = q.regs[c][`RTV_IX_ADAPT][`RTV_ADAPT_LSB +: 2]; // RQ11
    assign RATE_SEL_O[c*4 +: 4] = q.regs[c][`RTV_IX_RATE][`RTV_RATE_LSB +: 4];
    assign LINEAR_EQUALIZER_BOOST_O[c*8 +: 8] = q.regs[c][`RTV_IX_BOOST]; // RQ7
    assign OUTPUT_SWING_O[c*8 +: 8] = q.regs[c][`RTV_IX_SWING];
    assign DEEMPH_O[c*8 +: 8] = q.regs[c][`RTV_IX_DEEMPH];
    for (genvar t = 0; t < 5; t++) begin : g_tap
      assign FBEQ_TAP_O[(c*5+t)*8 +: 8] = q.regs[c][`RTV_IX_TAP0 + t];
    end
  end
endmodule

// ### src/rtvcal_consts.svh
`ifndef RTVCAL_CONSTS_SVH
`define RTVCAL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTV_OFS_FBEQ_PWR 8'h1E
`define RTV_OFS_RATE 8'h2F
`define RTV_OFS_ADAPT 8'h31
`define RTV_OFS_G0_LO 8'h60
`define RTV_OFS_G0_HI 8'h61
`define RTV_OFS_G1_LO 8'h62
`define RTV_OFS_G1_HI 8'h63
`define RTV_OFS_TOL 8'h64
`define RTV_OFS_BOOST 8'h40
`define RTV_OFS_SWING 8'h41
`define RTV_OFS_DEEMPH 8'h42
`define RTV_OFS_TAP0 8'h50
`define RTV_OFS_TAP4 8'h54
`define RTV_OFS_COARSE 8'h70
`define RTV_OFS_STAT 8'h71
`define RTV_OFS_CMD 8'h72
`define RTV_OFS_CHSEL 8'hFF

// ----------------------------------------------------------------------
// Storage indices inside one channel
// ----------------------------------------------------------------------
`define RTV_IX_FBEQ 4'h0
`define RTV_IX_RATE 4'h1
`define RTV_IX_ADAPT 4'h2
`define RTV_IX_G0_LO 4'h3
`define RTV_IX_G0_HI 4'h4
`define RTV_IX_G1_LO 4'h5
`define RTV_IX_G1_HI 4'h6
`define RTV_IX_TOL 4'h7
`define RTV_IX_BOOST 4'h8
`define RTV_IX_SWING 4'h9
`define RTV_IX_DEEMPH 4'hA
`define RTV_IX_TAP0 4'hB

// ----------------------------------------------------------------------
// Field positions, reset values and counts
// ----------------------------------------------------------------------
`define RTV_RST_FBEQ_PWR 8'h08
`define RTV_RST_ADAPT 8'h20
`define RTV_BIT_FBEQ_PD 3
`define RTV_ADAPT_LSB 5
`define RTV_RATE_LSB 4
`define RTV_BIT_MANUAL 7
`define RTV_CMD_CAL_BIT 0
`define RTV_CMD_ADAPT_BIT 1
`define RTV_CHSEL_BCAST_BIT 2
`define RTV_LOCK_TRIES 3'h4
`define RTV_SMB_ADDR 7'h18

`endif

// ### src/rtvcal_pkg.sv
package rtvcal_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_REQ, CAL_REL} rtvcal_cst_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WR, S_ACK, S_RD, S_RACK} rtvcal_sst_t;
  typedef logic [7:0] rtvcal_byte_t;
endpackage

// ### src/rtvcal_smbus.sv
`timescale 1ns/100ps
`include "rtvcal_consts.svh"
module rtvcal_smbus #(
  parameter logic [6:0] DEV_ADDR = `RTV_SMB_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic wr_o,
  output rtvcal_pkg::rtvcal_byte_t waddr_o,
  output rtvcal_pkg::rtvcal_byte_t wdata_o,
  output rtvcal_pkg::rtvcal_byte_t raddr_o,
  input wire rtvcal_pkg::rtvcal_byte_t rdata_i
);
  import rtvcal_pkg::*;

  typedef struct packed {
    logic [2:0] sc;
    logic [2:0] sd;
    logic scl;
    logic sda;
    rtvcal_sst_t st;
    rtvcal_sst_t nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic oe_n;
    logic low;
    logic wr;
    logic [7:0] wa;
    logic [7:0] wd;
  } rtvcal_smb_t;

  rtvcal_smb_t q;
  rtvcal_smb_t n;

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    n = q;
    n.wr = 1'b0;
    n.sc = {q.sc[1:0], scl_i};
    n.sd = {q.sd[1:0], sda_i};
    if (q.sc[2] == q.sc[1]) begin
      n.scl = q.sc[2];
    end
    if (q.sd[2] == q.sd[1]) begin
      n.sda = q.sd[2];
    end
    rise = n.scl & ~q.scl;
    fall = ~n.scl & q.scl;
    start = q.scl & n.scl & q.sda & ~n.sda;
    stop = q.scl & n.scl & ~q.sda & n.sda;
    if (start) begin
      n.st = S_ADDR;
      n.cnt = 4'h0;
      n.oe_n = 1'b1;
    end else if (stop) begin
      n.st = S_IDLE;
      n.oe_n = 1'b1;
    end else begin
      case (q.st)
        S_IDLE: begin
        end
        S_ADDR, S_REG, S_WR: begin
          if (rise) begin
            n.sh = {q.sh[6:0], n.sda};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'h8) begin
            n.cnt = 4'h0;
            n.st = S_ACK;
            n.oe_n = 1'b0;
            if (q.st == S_ADDR) begin
              n.nxt = q.sh[0] ? S_RD : S_REG;
              if (q.sh[7:1] != DEV_ADDR) begin
                n.st = S_IDLE;
                n.oe_n = 1'b1;
              end
            end else if (q.st == S_REG) begin
              n.ptr = q.sh;
              n.nxt = S_WR;
            end else begin
              n.wr = 1'b1;
              n.wa = q.ptr;
              n.wd = q.sh;
              n.ptr = q.ptr + 8'h01;
              n.nxt = S_WR;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            n.oe_n = 1'b1;
            n.st = q.nxt;
            if (q.nxt == S_RD) begin
              n.sh = rdata_i;
              n.oe_n = rdata_i[7];
              n.ptr = q.ptr + 8'h01;
            end
          end
        end
        S_RD: begin
          if (rise) begin
            n.sh = {q.sh[6:0], 1'b0};
            n.cnt = q.cnt + 4'h1;
          end else if (fall) begin
            if (q.cnt == 4'h8) begin
              n.oe_n = 1'b1;
              n.cnt = 4'h0;
              n.st = S_RACK;
            end else begin
              n.oe_n = q.sh[7];
            end
          end
        end
        S_RACK: begin
          // A not-acknowledge from the host ends the read burst.
          if (rise && n.sda) begin
            n.st = S_IDLE;
          end else if (fall) begin
            n.sh = rdata_i;
            n.oe_n = rdata_i[7];
            n.ptr = q.ptr + 8'h01;
            n.st = S_RD;
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.sc <= 3'h7;
      q.sd <= 3'h7;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sda_o = q.low;
  assign sda_oe_n_o = q.oe_n;
  assign wr_o = q.wr;
  assign waddr_o = q.wa;
  assign wdata_o = q.wd;
  assign raddr_o = q.ptr;
endmodule

// ### testbench/rtvcal_monitor.sv
`timescale 1ns/100ps
module rtvcal_mon #(
  parameter int COARSE_W = 5
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [3:0] LOCK_I,
  input wire logic [3:0] CDR_RESET_I,
  input wire logic MEAS_DONE_I,
  input wire logic MEAS_REQ_O,
  input wire logic [1:0] MEAS_CH_O,
  input wire logic [COARSE_W-1:0] COARSE_TRY_O,
  input wire logic [3:0] LOCK_OK_O,
  input wire logic [3:0] CDR_RESTART_O,
  input wire logic [3:0] ADAPT_START_O,
  input wire logic [3:0] FEEDBACK_EQ_POWERDOWN_O,
  input wire logic [7:0] ADAPT_MODE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // -------------------------------------------------
  // Measurement handshake steps
  // -------------------------------------------------
  sequence s_done_up;
    $rose(MEAS_DONE_I) && MEAS_REQ_O;
  endsequence
  sequence s_req_drop;
    $fell(MEAS_REQ_O) && MEAS_DONE_I;
  endsequence
  AST_RST_VALUES: assert property (
    $rose(RSTN_I) |-> FEEDBACK_EQ_POWERDOWN_O == 4'hF && ADAPT_MODE_O == 8'h55)
    else $error("powerdown or adaptation mode not at reset value");
  AST_BOOT_CAL: assert property (
    $rose(RSTN_I) |-> ##[1:3] (MEAS_REQ_O && MEAS_CH_O == 2'h0 && COARSE_TRY_O == '0))
    else $error("no calibration of channel 0 after reset");
  AST_REQ_HOLD: assert property (
    MEAS_REQ_O && !MEAS_DONE_I |=> MEAS_REQ_O && $stable(COARSE_TRY_O) && $stable(MEAS_CH_O))
    else $error("measurement request moved before done");
  AST_REQ_DROP: assert property (
    s_done_up |-> ##[1:6] !MEAS_REQ_O)
    else $error("measurement request not withdrawn after done");
  AST_REQ_WAIT: assert property (
    s_req_drop |=> !MEAS_REQ_O [*2])
    else $error("new request while done still high");
  AST_CDR_ADAPT: assert property (
    $rose(CDR_RESET_I[0]) |-> ##[1:8] ADAPT_START_O[0])
    else $error("no adaptation start after recovery reset");
  AST_LOCK_DROP: assert property (
    $fell(LOCK_I[0]) |-> ##[1:8] !LOCK_OK_O[0])
    else $error("lock accepted flag kept after lock loss");
  AST_OK_ADAPT: assert property (
    $rose(LOCK_OK_O[0]) |-> ##[0:1] ADAPT_START_O[0])
    else $error("accepted lock without adaptation start");
  AST_REJECT: assert property (
    CDR_RESTART_O[0] |-> !LOCK_OK_O[0] ##1 !CDR_RESTART_O[0])
    else $error("rejected lock accepted or restart too long");
endmodule

bind rtvcal_top rtvcal_mon #(.COARSE_W(COARSE_W)) u_mon (
  .CORE_CLK_I(CORE_CLK_I),
  .RSTN_I(RSTN_I),
  .LOCK_I(LOCK_I),
  .CDR_RESET_I(CDR_RESET_I),
  .MEAS_DONE_I(MEAS_DONE_I),
  .MEAS_REQ_O(MEAS_REQ_O),
  .MEAS_CH_O(MEAS_CH_O),
  .COARSE_TRY_O(COARSE_TRY_O),
  .LOCK_OK_O(LOCK_OK_O),
  .CDR_RESTART_O(CDR_RESTART_O),
  .ADAPT_START_O(ADAPT_START_O),
  .FEEDBACK_EQ_POWERDOWN_O(FEEDBACK_EQ_POWERDOWN_O),
  .ADAPT_MODE_O(ADAPT_MODE_O)
);

// ### testbench/rtvcal_smb_host.sv
`timescale 1ns/100ps
`include "rtvcal_consts.svh"
module rtvcal_smb_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // -------------------------------------------------
  // Bit level
  // -------------------------------------------------
  // Each phase lasts ten core cycles, twice the minimum, so data never moves with a clock edge.
  task automatic hp;
    repeat (10) @(posedge clk_i);
    #10;
  endtask
  task automatic start_c;
    hp;
    sda_o = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_o = 1'b0;
    hp;
    scl_o = 1'b0;
  endtask
  task automatic stop_c;
    hp;
    sda_o = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_o = 1'b1;
    hp;
  endtask
  task automatic bit_c(input logic b, output logic r);
    hp;
    sda_o = b;
    hp;
    scl_o = 1'b1;
    hp;
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  // -------------------------------------------------
  // Register access
  // -------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    start_c;
    tx({`RTV_SMB_ADDR, 1'b0}, k);
    tx(a, k);
    tx(d, k);
    stop_c;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    logic r;
    start_c;
    tx({`RTV_SMB_ADDR, 1'b0}, k);
    tx(a, k);
    start_c;
    tx({`RTV_SMB_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, r);
      d[i] = r;
    end
    bit_c(1'b1, r);
    stop_c;
  endtask
  task automatic probe(input logic [7:0] a, output logic ack);
    start_c;
    tx(a, ack);
    stop_c;
  endtask
endmodule

// ### testbench/retimer_vco_cal_and_eq_config_tb_top.sv
`timescale 1ns/100ps
`include "rtvcal_consts.svh"
module retimer_vco_cal_and_eq_config_tb_top;
  logic clk, rstn, scl, hsda, done, req, oe_n, sdo;
  logic [3:0] lock, cdr_rst, acq_tgl, lock_ok, restart, adapt_st, pd, ch_seen, adapt_seen;
  logic [15:0] cnt, skew, rate;
  logic [1:0] mch;
  logic [4:0] try;
  logic [19:0] coarse;
  logic [7:0] amode;
  logic [31:0] boost, swing, deemph;
  logic [159:0] taps;
  int bad_count, tests_run, meas_n;
  // Pulled-up line: low when the host drives low or the device enables its low driver.
  wire sda = hsda & (oe_n | sdo);

  rtvcal_top #(.COARSE_W(5), .CNT_W(16)) i_dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .SMB_SCL_I(scl), .SMB_SDA_I(sda), .SMB_SDA_O(sdo),
    .SMB_SDA_OE_N_O(oe_n), .LOCK_I(lock), .CDR_RESET_I(cdr_rst), .ACQ_FAIL_TGL_I(acq_tgl),
    .MEAS_DONE_I(done), .MEAS_COUNT_I(cnt), .MEAS_REQ_O(req), .MEAS_CH_O(mch),
    .COARSE_TRY_O(try), .COARSE_O(coarse), .LOCK_OK_O(lock_ok), .CDR_RESTART_O(restart),
    .ADAPT_START_O(adapt_st), .FEEDBACK_EQ_POWERDOWN_O(pd), .ADAPT_MODE_O(amode),
    .RATE_SEL_O(rate), .LINEAR_EQUALIZER_BOOST_O(boost), .OUTPUT_SWING_O(swing),
    .DEEMPH_O(deemph), .FBEQ_TAP_O(taps)
  );
  rtvcal_smb_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counter model: count rises 0x20 per coarse code, so code 16 lands on 0x3200.
  always begin
    @(posedge clk iff req === 1'b1);
    repeat (2) @(posedge clk);
    #10;
    cnt = 16'h3000 + {try, 5'h00} + skew;
    ch_seen[mch] = 1'b1;
    meas_n++;
    done = 1'b1;
    @(posedge clk iff req === 1'b0);
    #10;
    done = 1'b0;
    cnt = ~cnt;
  end
  // Adaptation starts are single-cycle pulses, so they are gathered into a sticky mask.
  always @(negedge clk) adapt_seen = adapt_seen | adapt_st;
  // -------------------------------------------------
  // Helpers
  // -------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(n, d, e);
  endtask
  task automatic tick;
    @(posedge clk);
    #10;
  endtask
  task automatic wait_idle;
    int q;
    q = 0;
    for (int n = 0; n < 9000 && q < 60; n++) begin
      @(negedge clk);
      q = req ? 0 : q + 1;
    end
    chk("idle_limit", q >= 60, 1'b1);
  endtask
  task automatic wait_hi(input int sel, output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 400 && seen !== 1'b1; n++) begin
      @(negedge clk);
      seen = (sel == 0) ? lock_ok[0] : restart[0];
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #8000000;
    bad_count++;
    close_out;
  end
  // -------------------------------------------------
  // Tests
  // -------------------------------------------------
  initial begin
    logic s;
    {rstn, done, cnt, skew, lock, cdr_rst, acq_tgl, ch_seen, adapt_seen, meas_n} = '0;
    repeat (8) @(posedge clk);
    #10;
    rstn = 1'b1;
    chk("pd_rst", pd, 4'hF);
    chk("mode_rst", amode, 8'h55);
    wait_idle;
    chk("boot_channels", ch_seen, 4'hF);
    chk("boot_codes", meas_n, 128);
    chk("boot_coarse", coarse, 20'h0);
    rchk("fbeq_rst", `RTV_OFS_FBEQ_PWR, 8'h08);
    rchk("adapt_rst", `RTV_OFS_ADAPT, 8'h20);
    rchk("unmapped", 8'h10, 8'h00);
    i_host.probe(8'h40, s);
    chk("foreign_addr_ack", s, 1'b0);
    $display("test reset done");
    i_host.wr(`RTV_OFS_FBEQ_PWR, 8'h00);
    chk("pd_clr", pd, 4'hE);
    for (int m = 0; m < 4; m++) begin
      i_host.wr(`RTV_OFS_ADAPT, 8'(m << 5));
      chk("mode", amode, {6'h15, 2'(m)});
    end
    i_host.wr(`RTV_OFS_CHSEL, 8'h01);
    i_host.wr(`RTV_OFS_SWING, 8'h5A);
    i_host.wr(`RTV_OFS_DEEMPH, 8'h3C);
    i_host.wr(`RTV_OFS_BOOST, 8'hE4);
    i_host.wr(`RTV_OFS_RATE, 8'hF0);
    for (int t = 0; t < 5; t++) i_host.wr(8'(`RTV_OFS_TAP0 + t), 8'(8'h80 + t));
    chk("swing", swing, 32'h00005A00);
    chk("deemph", deemph, 32'h00003C00);
    chk("rate", rate, 16'h00F0);
    for (int g = 0; g < 4; g++) chk("stage", boost[8+2*g+:2], g);
    for (int t = 0; t < 5; t++) chk("tap", taps[(5+t)*8+:8], 8'h80 + t);
    rchk("swing_rd", `RTV_OFS_SWING, 8'h5A);
    i_host.wr(`RTV_OFS_CHSEL, 8'h00);
    $display("test settings done");
    i_host.wr(`RTV_OFS_G0_LO, 8'h00);
    i_host.wr(`RTV_OFS_G0_HI, 8'hB2);
    i_host.wr(`RTV_OFS_TOL, 8'h00);
    meas_n = 0;
    adapt_seen = '0;
    cdr_rst[0] = 1'b1;
    wait_idle;
    tick;
    cdr_rst[0] = 1'b0;
    chk("recal_codes", meas_n, 32);
    chk("coarse_best", coarse, 20'd16);
    chk("cdr_adapt", adapt_seen, 4'h1);
    $display("test calibration done");
    tick;
    lock[0] = 1'b1;
    wait_hi(0, s);
    chk("lock_ok", s, 1'b1);
    tick;
    lock[0] = 1'b0;
    skew = 16'h0040;
    wait_idle;
    tick;
    lock[0] = 1'b1;
    wait_hi(1, s);
    chk("reject", s, 1'b1);
    chk("not_ok", lock_ok[0], 1'b0);
    tick;
    lock[0] = 1'b0;
    meas_n = 0;
    for (int k = 0; k < 3; k++) begin
      repeat (10) @(posedge clk);
      #10;
      acq_tgl[0] = ~acq_tgl[0];
    end
    wait_idle;
    chk("fail_recal_codes", meas_n, 32);
    chk("coarse_new", coarse[4:0], 5'd14);
    $display("test lock done");
    adapt_seen = '0;
    ch_seen = '0;
    meas_n = 0;
    i_host.wr(`RTV_OFS_CHSEL, 8'h04);
    i_host.wr(`RTV_OFS_DEEMPH, 8'h11);
    chk("bcast", deemph, 32'h11111111);
    i_host.wr(`RTV_OFS_CHSEL, 8'h02);
    i_host.wr(`RTV_OFS_CMD, 8'h03);
    wait_idle;
    chk("cmd_codes", meas_n, 32);
    chk("cmd_ch", ch_seen, 4'h4);
    chk("cmd_adapt", adapt_seen, 4'h4);
    i_host.wr(`RTV_OFS_CHSEL, 8'h00);
    rchk("coarse_rd", `RTV_OFS_COARSE, 8'h0E);
    i_host.wr(`RTV_OFS_G1_HI, 8'hB2);
    i_host.wr(`RTV_OFS_TOL, 8'h20);
    skew = 16'h0042;
    lock[0] = 1'b1;
    wait_hi(0, s);
    chk("g1_ok", s, 1'b1);
    $display("test command done");
    close_out;
  end
endmodule
